// file: verilog/nvm_prot_regs.svh
// Purpose: offsets, field positions, reset values and limits
// Assumes: 8-bit register port, 16-bit global addresses
// Notes: definitions only
`ifndef NVM_PROT_REGS_SVH
`define NVM_PROT_REGS_SVH
// ==========================================
// register offsets
`define OFS_STATUS 3'h0
`define OFS_CONFIG 3'h1
`define OFS_ERRCFG 3'h2
`define OFS_FLASH_PROT_REG 3'h3
`define OFS_EPROT 3'h4
`define OFS_SEC 3'h5
// ==========================================
// field positions
`define ST_CMD_DONE 7
`define ST_PVIOL 5
`define ST_DBL 1
`define ST_SGL 0
`define CF_CMD_IE 7
`define EC_DBL_IE 1
`define EC_SGL_IE 0
`define FP_OPEN 7
`define FP_HDIS 5
`define FP_LDIS 2
`define EP_OPEN 7
// ==========================================
// reset values and addresses
`define RST_BYTE 8'hff
`define RST_SEC 8'h00
`define SEC_OPEN 2'h2
`define FLASH_BASE 16'h8000
`define FLASH_TOP 16'hffff
`define EE_BASE 16'h3100
`define EE_STEP 16'h0020
`define NV_KEY_LO 16'hff70
`define NV_KEY_HI 16'hff77
`define NV_FLASH_PROT_REG 16'hff7c
`define NV_EPROT 16'hff7d
`define NV_OPT 16'hff7e
`define NV_SEC 16'hff7f
`endif

// file: verilog/nvm_prot_pkg.sv
// Purpose: types shared by the protection block and its bench
// Assumes: nothing
// Notes: numbers live in nvm_prot_regs.svh
package nvm_prot_pkg;
  typedef enum logic [1:0] {
    OP_PROGRAM = 2'b00,
    OP_ERASE = 2'b01,
    OP_ERASE_ALL = 2'b10
  } op_kind_t;
  typedef struct packed {
    logic valid;
    op_kind_t kind;
    logic [15:0] addr;
  } prot_req_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } load_state_t;
endpackage

// file: verilog/nvm_protection_security_irq.sv
// Purpose: interrupt requests, flash/eeprom protection and security state
// Assumes: nonvolatile bytes are valid on their inputs at reset release
// Notes: configuration is captured in the first cycle after reset
// How it works
// - command irq = done flag and enable
// - error irq from enabled fault flags
// - low, high and middle flash regions
// - block program/erase of protected flash
// - flash protection loaded from 0xff7c
// - open bit inverts meaning of ranges
// - disallowed protection writes are ignored
// - transition matrix between eight scenarios
// - protection read shows active scenario
// - high range size starts f800..c000
// - low range size ends 83ff..9fff
// - eeprom protection loaded from 0xff7d
// - eeprom range 32 bytes per step
// - protection stays writable after load
// - security loaded from 0xff7f
// - new security byte waits for reset
// - configuration field address layout
// - done flag low while command runs
// - ecc errors set fault flags
// - erase all needs everything open
`timescale 1ns/1ps
`default_nettype none
`include "nvm_prot_regs.svh"
module nvm_protection_security_irq #(
  parameter logic [23:0] SCEN_MAP = 24'he887ac,
  parameter logic [63:0] ALLOW = 64'hff5a3c18080c0a0f
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire nvm_prot_pkg::reg_req_t reg_req,
  output logic [7:0] rd_data,
  input wire logic [7:0] nv_flash_prot_reg_byte,
  input wire logic [7:0] nv_eprot_byte,
  input wire logic [7:0] nv_sec_byte,
  input wire logic cmd_launch,
  input wire logic cmd_finish,
  input wire logic ecc_dbl_err,
  input wire logic ecc_sgl_err,
  input wire nvm_prot_pkg::prot_req_t prot_req,
  output logic req_grant,
  output logic req_abort,
  output logic cmd_irq,
  output logic err_irq,
  output logic secured,
  output logic cfg_loaded
);
  import nvm_prot_pkg::*;

  // ==========================================
  // helpers
  // scenario number of an {open,hdis,ldis} triple
  function automatic logic [2:0] scen_of(input logic [2:0] b);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (SCEN_MAP[i*3 +: 3] == b) begin
        s = 3'(i);
      end
    end
    return s;
  endfunction

  function automatic logic [2:0] bits_of(input logic [7:0] r);
    return {r[`FP_OPEN], r[`FP_HDIS], r[`FP_LDIS]};
  endfunction

  // flash protection decode
  function automatic logic flash_prot(input logic [7:0] r, input logic [15:0] a);
    logic in_hi;
    logic in_lo;
    logic hit;
    in_hi = (a >= (`FLASH_TOP - ((16'h0800 << r[4:3]) - 16'h0001)));
    in_lo = (a >= `FLASH_BASE) && (a <= (`FLASH_BASE + ((16'h0400 << r[1:0]) - 16'h0001)));
    hit = (!r[`FP_HDIS] && in_hi) || (!r[`FP_LDIS] && in_lo);
    if (r[`FP_OPEN]) begin
      return hit;
    end
    return (a >= `FLASH_BASE) && !hit;
  endfunction

  // ==========================================
  // state
  load_state_t state_q;
  logic [7:0] flash_prot_reg_q;
  logic [7:0] eprot_q;
  logic [7:0] sec_q;
  logic cmd_done_q;
  logic pviol_q;
  logic dbl_q;
  logic sgl_q;
  logic cmd_ie_q;
  logic dbl_ie_q;
  logic sgl_ie_q;
  logic [7:0] rd_data_q;
  logic wr_flash_prot_reg_ok;
  logic wr_eprot_ok;
  logic is_flash;
  logic ee_hit;
  logic all_open;
  logic blocked;
  logic wr_st;

  assign wr_st = reg_req.wr && reg_req.addr == `OFS_STATUS;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_LOAD;
    end else begin
      state_q <= ST_RUN;
    end
  end

  // ==========================================
  // protection checks
  always_comb begin
    wr_flash_prot_reg_ok = ALLOW[scen_of(bits_of(flash_prot_reg_q))*8 + 32'(scen_of(bits_of(reg_req.wdata)))];
    wr_eprot_ok = (reg_req.wdata[`EP_OPEN] <= eprot_q[`EP_OPEN]) &&
                  (eprot_q[`EP_OPEN] || reg_req.wdata[2:0] >= eprot_q[2:0]);
  end

  assign is_flash = prot_req.addr >= `FLASH_BASE;
  // eeprom range grows 32 bytes per size step
  assign ee_hit = !eprot_q[`EP_OPEN] && prot_req.addr >= `EE_BASE &&
                  prot_req.addr < (`EE_BASE + (`EE_STEP * (16'(eprot_q[2:0]) + 16'h0001)));
  assign all_open = flash_prot_reg_q[`FP_OPEN] && flash_prot_reg_q[`FP_HDIS] && flash_prot_reg_q[`FP_LDIS] &&
                    eprot_q[`EP_OPEN];

  always_comb begin
    if (prot_req.kind == OP_ERASE_ALL) begin
      blocked = !all_open;
    end else if (is_flash) begin
      blocked = flash_prot(flash_prot_reg_q, prot_req.addr);
    end else begin
      blocked = ee_hit;
    end
  end

  assign req_grant = prot_req.valid && state_q == ST_RUN && !blocked;
  assign req_abort = prot_req.valid && state_q == ST_RUN && blocked;

  // ==========================================
  // protection and security registers
  // bytes come from the configuration field at ff7c, ff7d and ff7f
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_prot_reg_q <= `RST_BYTE;
    end else if (state_q == ST_LOAD) begin
      flash_prot_reg_q <= nv_flash_prot_reg_byte;
    end else if (reg_req.wr && reg_req.addr == `OFS_FLASH_PROT_REG && wr_flash_prot_reg_ok) begin
      flash_prot_reg_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eprot_q <= `RST_BYTE;
    end else if (state_q == ST_LOAD) begin
      eprot_q <= {nv_eprot_byte[`EP_OPEN], 4'h0, nv_eprot_byte[2:0]};
    end else if (reg_req.wr && reg_req.addr == `OFS_EPROT && wr_eprot_ok) begin
      eprot_q <= {reg_req.wdata[`EP_OPEN], 4'h0, reg_req.wdata[2:0]};
    end
  end

  // only the load state writes security, later programming waits for reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_q <= `RST_SEC;
    end else if (state_q == ST_LOAD) begin
      sec_q <= nv_sec_byte;
    end
  end

  // ==========================================
  // flags: hardware set wins over write-one clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_done_q <= 1'b1;
    end else if (cmd_finish) begin
      cmd_done_q <= 1'b1;
    end else if (cmd_launch) begin
      cmd_done_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbl_q <= 1'b0;
      sgl_q <= 1'b0;
      pviol_q <= 1'b0;
    end else begin
      dbl_q <= ecc_dbl_err || (dbl_q && !(wr_st && reg_req.wdata[`ST_DBL]));
      sgl_q <= ecc_sgl_err || (sgl_q && !(wr_st && reg_req.wdata[`ST_SGL]));
      pviol_q <= req_abort || (pviol_q && !(wr_st && reg_req.wdata[`ST_PVIOL]));
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_ie_q <= 1'b0;
      dbl_ie_q <= 1'b0;
      sgl_ie_q <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == `OFS_CONFIG) begin
      cmd_ie_q <= reg_req.wdata[`CF_CMD_IE];
    end else if (reg_req.wr && reg_req.addr == `OFS_ERRCFG) begin
      dbl_ie_q <= reg_req.wdata[`EC_DBL_IE];
      sgl_ie_q <= reg_req.wdata[`EC_SGL_IE];
    end
  end

  // ==========================================
  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `OFS_STATUS: rd_data_q <= {cmd_done_q, 1'b0, pviol_q, 3'h0, dbl_q, sgl_q};
        `OFS_CONFIG: rd_data_q <= {cmd_ie_q, 7'h00};
        `OFS_ERRCFG: rd_data_q <= {6'h00, dbl_ie_q, sgl_ie_q};
        `OFS_FLASH_PROT_REG: rd_data_q <= flash_prot_reg_q;
        `OFS_EPROT: rd_data_q <= eprot_q;
        `OFS_SEC: rd_data_q <= sec_q;
        default: rd_data_q <= 8'h00;
      endcase
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  assign rd_data = rd_data_q;
  assign cmd_irq = cmd_done_q && cmd_ie_q;
  assign err_irq = (dbl_q && dbl_ie_q) || (sgl_q && sgl_ie_q);
  assign secured = sec_q[1:0] != `SEC_OPEN;
  assign cfg_loaded = state_q == ST_RUN;

  // ==========================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_cmd_irq;
    $rose(cmd_done_q) && cmd_ie_q |-> cmd_irq;
  endproperty
  a_cmd_irq: assert property (p_cmd_irq) else $error("cmd irq missing");

  property p_err_irq;
    ecc_dbl_err && dbl_ie_q && !(reg_req.wr && reg_req.addr == `OFS_ERRCFG) |=> err_irq;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("err irq missing");

  property p_low_region;
    prot_req.valid && cfg_loaded && prot_req.kind == OP_PROGRAM && flash_prot_reg_q[`FP_OPEN] &&
    !flash_prot_reg_q[`FP_LDIS] && prot_req.addr[15:10] == 6'h20 |-> req_abort && !req_grant;
  endproperty
  a_low_region: assert property (p_low_region) else $error("low region open");

  property p_abort_flag;
    req_abort |=> pviol_q;
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("violation not flagged");

  property p_load;
    $rose(cfg_loaded) |-> flash_prot_reg_q == $past(nv_flash_prot_reg_byte) && sec_q == $past(nv_sec_byte);
  endproperty
  a_load: assert property (p_load) else $error("config not loaded");

  property p_ignore;
    cfg_loaded && reg_req.wr && reg_req.addr == `OFS_FLASH_PROT_REG && !wr_flash_prot_reg_ok |=> $stable(flash_prot_reg_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("bad transition taken");

  property p_read;
    reg_req.rd && reg_req.addr == `OFS_FLASH_PROT_REG |=> rd_data == $past(flash_prot_reg_q);
  endproperty
  a_read: assert property (p_read) else $error("protection read wrong");

  property p_sec_hold;
    cfg_loaded ##1 cfg_loaded |-> $stable(sec_q);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("security changed");

  property p_erase_all;
    prot_req.valid && prot_req.kind == OP_ERASE_ALL && !all_open |-> !req_grant;
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("erase all granted");

  property p_launch;
    cmd_launch && !cmd_finish |=> !cmd_done_q [*1] ##0 !cmd_irq;
  endproperty
  a_launch: assert property (p_launch) else $error("done flag not cleared");

  property p_dbl;
    ecc_dbl_err |=> dbl_q;
  endproperty
  a_dbl: assert property (p_dbl) else $error("double fault lost");

  c_abort: cover property (req_abort ##1 pviol_q);
  c_prot_write: cover property (reg_req.wr && reg_req.addr == `OFS_FLASH_PROT_REG && wr_flash_prot_reg_ok);
  c_err_irq: cover property (sgl_q && sgl_ie_q);
  c_erase_all: cover property (prot_req.valid && prot_req.kind == OP_ERASE_ALL && req_grant);
  c_cmd_cycle: cover property ($fell(cmd_done_q) ##[1:20] $rose(cmd_done_q));

  property p_high_region;
    prot_req.valid && cfg_loaded && prot_req.kind != OP_ERASE_ALL && flash_prot_reg_q[`FP_OPEN] &&
    !flash_prot_reg_q[`FP_HDIS] && prot_req.addr[15:11] == 5'h1f |-> req_abort && !req_grant;
  endproperty
  a_high_region: assert property (p_high_region) else $error("high region open");

  property p_ee_region;
    prot_req.valid && cfg_loaded && prot_req.kind != OP_ERASE_ALL && !eprot_q[`EP_OPEN] &&
    prot_req.addr[15:5] == 11'h188 |-> req_abort;
  endproperty
  a_ee_region: assert property (p_ee_region) else $error("eeprom region open");

  property p_flash_open;
    prot_req.valid && cfg_loaded && prot_req.kind != OP_ERASE_ALL && is_flash &&
    bits_of(flash_prot_reg_q) == 3'b111 |-> req_grant;
  endproperty
  a_flash_open: assert property (p_flash_open) else $error("open flash refused");

  property p_flash_closed;
    prot_req.valid && cfg_loaded && prot_req.kind != OP_ERASE_ALL && is_flash &&
    bits_of(flash_prot_reg_q) == 3'b011 |-> req_abort;
  endproperty
  a_flash_closed: assert property (p_flash_closed) else $error("closed flash granted");

  property p_no_early;
    !cfg_loaded |-> !req_grant && !req_abort;
  endproperty
  a_no_early: assert property (p_no_early) else $error("answer before load");

  property p_sgl;
    ecc_sgl_err |=> sgl_q;
  endproperty
  a_sgl: assert property (p_sgl) else $error("single fault lost");

  property p_finish;
    cmd_finish |=> cmd_done_q;
  endproperty
  a_finish: assert property (p_finish) else $error("done flag not set");

  property p_eprot_ignore;
    cfg_loaded && reg_req.wr && reg_req.addr == `OFS_EPROT && !wr_eprot_ok |=> $stable(eprot_q);
  endproperty
  a_eprot_ignore: assert property (p_eprot_ignore) else $error("eeprom protection removed");

  property p_rd_idle;
    !reg_req.rd |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
endmodule
`default_nettype wire

// file: testbench/seq_model.sv
// Purpose: stand-in for the command sequencer, one command per start pulse
// Assumes: start is a one-cycle pulse
// Notes: wait_cycles sets how long a command runs, so both quick and slow answers are possible
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [3:0] wait_cycles,
  output logic cmd_launch,
  output logic cmd_finish
);
  logic [3:0] cnt_q;
  logic busy_q;
  // ==========================================
  // launch, run, finish
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      cmd_launch <= 1'b0;
      cmd_finish <= 1'b0;
    end else begin
      cmd_launch <= start && !busy_q;
      cmd_finish <= busy_q && cnt_q == 4'h0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= wait_cycles;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/nvm_protection_security_irq_tb.sv
// Purpose: self-checking bench for protection, security and interrupt requests
// Assumes: sequencer model drives the command pulses
// Notes: most cases start from a fresh reset with new nonvolatile bytes
`timescale 1ns/1ps
`default_nettype none
`include "nvm_prot_regs.svh"
module nvm_protection_security_irq_tb;
  import nvm_prot_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t reg_req = '0;
  prot_req_t prot_req = '0;
  logic [7:0] rd_data;
  logic [7:0] fp = 8'hff, ep = 8'hff, sc = 8'h02, r;
  logic cmd_launch, cmd_finish, req_grant, req_abort, cmd_irq, err_irq, secured, cfg_loaded;
  logic dbl = 1'b0, sgl = 1'b0, start = 1'b0;
  int miscompares = 0, comparisons = 0, cycles = 0;
  logic [2:0] code [8] = '{3'b100, 3'b101, 3'b110, 3'b011, 3'b000, 3'b001, 3'b010, 3'b111};
  logic [7:0] allow [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
  logic [15:0] hi_start [4] = '{16'hf800, 16'hf000, 16'he000, 16'hc000};
  logic [15:0] lo_end [4] = '{16'h83ff, 16'h87ff, 16'h8fff, 16'h9fff};
  nvm_protection_security_irq u_nvm_protection_security_irq (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .rd_data(rd_data), .nv_flash_prot_reg_byte(fp), .nv_eprot_byte(ep), .nv_sec_byte(sc),
    .cmd_launch(cmd_launch), .cmd_finish(cmd_finish), .ecc_dbl_err(dbl), .ecc_sgl_err(sgl),
    .prot_req(prot_req), .req_grant(req_grant), .req_abort(req_abort), .cmd_irq(cmd_irq),
    .err_irq(err_irq), .secured(secured), .cfg_loaded(cfg_loaded));
  seq_model u_seq_model (.core_clk(core_clk), .sys_rst(sys_rst), .start(start), .wait_cycles(4'h6),
    .cmd_launch(cmd_launch), .cmd_finish(cmd_finish));
  // ==========================================
  // clock and timeout
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ==========================================
  // access tasks
  task automatic report_and_stop;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic [7:0] f, input logic [7:0] e);
    @(posedge core_clk);
    fp <= f;
    ep <= e;
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    r = rd_data;
  endtask
  task automatic req(input op_kind_t k, input logic [15:0] a, input logic g);
    @(posedge core_clk);
    prot_req <= '{valid: 1'b1, kind: k, addr: a};
    #1;
    chk(req_grant, g);
    chk(req_abort, !g);
  endtask
  function automatic logic [7:0] enc(input int s);
    enc = {code[s][2], 1'b0, code[s][1], 2'b00, code[s][0], 2'b00};
  endfunction
  // ==========================================
  // tests
  initial begin
    rst(8'hff, 8'hff);
    chk(cfg_loaded, 1'b1);
    chk(secured, 1'b0);
    req(OP_PROGRAM, 16'hffff, 1'b1);
    @(posedge core_clk);
    sc <= 8'h00;
    wr(`OFS_SEC, 8'h00);
    rd(`OFS_SEC);
    chk(r, 8'h02);
    chk(secured, 1'b0);
    rd(`OFS_FLASH_PROT_REG);
    chk(r & 8'hbf, 8'hbf);
    rd(`OFS_EPROT);
    chk(r & 8'h87, 8'h87);
    wr(3'h7, 8'h5a);
    rd(3'h7);
    chk(r, 8'h00);
    req(OP_ERASE_ALL, 16'h8000, 1'b1);
    wr(`OFS_CONFIG, 8'h80);
    chk(cmd_irq, 1'b1);
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(cmd_irq, 1'b0);
    repeat (12) @(posedge core_clk);
    #1;
    chk(cmd_irq, 1'b1);
    @(posedge core_clk);
    dbl <= 1'b1;
    @(posedge core_clk);
    dbl <= 1'b0;
    #1;
    chk(err_irq, 1'b0);
    wr(`OFS_ERRCFG, 8'h02);
    chk(err_irq, 1'b1);
    wr(`OFS_STATUS, 8'h02);
    chk(err_irq, 1'b0);
    @(posedge core_clk);
    sgl <= 1'b1;
    @(posedge core_clk);
    sgl <= 1'b0;
    wr(`OFS_ERRCFG, 8'h01);
    chk(err_irq, 1'b1);
    rst(8'hff, 8'h00);
    chk(secured, 1'b1);
    req(OP_ERASE_ALL, 16'h8000, 1'b0);
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        rst(enc(f), 8'hff);
        wr(`OFS_FLASH_PROT_REG, enc(t));
        rd(`OFS_FLASH_PROT_REG);
        chk(r & 8'hbf, allow[f][t] ? enc(t) : enc(f));
      end
    end
    for (int k = 0; k < 8; k++) begin
      rst({3'b100, k[1:0], 1'b0, k[1:0]}, {5'b00000, k[2:0]});
      req(OP_PROGRAM, hi_start[k[1:0]] - 16'h1, 1'b1);
      req(OP_ERASE, hi_start[k[1:0]], 1'b0);
      req(OP_PROGRAM, lo_end[k[1:0]], 1'b0);
      req(OP_ERASE, lo_end[k[1:0]] + 16'h1, 1'b1);
      req(OP_PROGRAM, 16'h30ff, 1'b1);
      req(OP_PROGRAM, 16'h3100 + 16'(32 * k + 31), 1'b0);
      req(OP_ERASE, 16'h3100 + 16'(32 * k + 32), 1'b1);
    end
    rd(`OFS_STATUS);
    chk(r[`ST_PVIOL], 1'b1);
    wr(`OFS_STATUS, 8'h20);
    rd(`OFS_STATUS);
    chk(r[`ST_PVIOL], 1'b0);
    wr(`OFS_EPROT, 8'h86);
    rd(`OFS_EPROT);
    chk(r, 8'h07);
    rst(8'h00, 8'hff);
    req(OP_PROGRAM, 16'hf7ff, 1'b0);
    req(OP_PROGRAM, 16'hf800, 1'b1);
    req(OP_ERASE, 16'h8400, 1'b0);
    req(OP_ERASE, 16'h83ff, 1'b1);
    rst(8'h24, 8'hff);
    req(OP_PROGRAM, 16'h9000, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
